/* File: include/exec_map.svh */
// Encodings, field positions and reset values for the three-instruction execute block
`ifndef EXEC_MAP_SVH
`define EXEC_MAP_SVH

// ----------------------------------------------------------------------------
// Instruction word fields
// ----------------------------------------------------------------------------
`define IW_W            12
`define OPC7_HI         11
`define OPC7_LO         6
`define DEST_BIT        5
`define FADDR_HI        4
`define FADDR_LO        0
`define LIT_HI          7
`define LIT_LO          0
`define TRISTATE_LOAD_OP_OPC_HI     11
`define TRISTATE_LOAD_OP_OPC_LO     3
`define TRISTATE_LOAD_OP_SEL_HI     2
`define TRISTATE_LOAD_OP_SEL_LO     0
`define XOR_OPC_HI      11
`define XOR_OPC_LO      8

// ----------------------------------------------------------------------------
// Opcode patterns
// ----------------------------------------------------------------------------
`define SWAP_OPC        6'hE
`define TRISTATE_LOAD_OP_OPC        9'h000
`define TRISTATE_LOAD_OP_GP_SEL     3'h6
`define XOR_OPC         4'hF

// ----------------------------------------------------------------------------
// Nibble positions and reset values
// ----------------------------------------------------------------------------
`define NIB_HI_HI       7
`define NIB_HI_LO       4
`define NIB_LO_HI       3
`define NIB_LO_LO       0
`define ACC_RST         8'h00
`define DIR_RST         8'hFF
`define ZERO_BYTE       8'h00

`endif

/* File: include/exec_pkg.sv */
// Types shared by the execute block files
package exec_pkg;
    // Write request toward the register file
    typedef struct packed {
        logic       en;
        logic [4:0] addr;
        logic [7:0] data;
    } file_wr_s;

    // Operation chosen by the decoder
    typedef enum logic [1:0] {
        OP_NONE,
        OP_SWAP,
        OP_TRISTATE_LOAD_OP,
        OP_XOR
    } op_e;
endpackage

/* File: src/exec_decode.sv */
// Decoder that classifies an instruction word into one of the three operations, or none
`timescale 1ns/1ps
`default_nettype none
`include "exec_map.svh"
module exec_decode
    import exec_pkg::*;
(
    input  wire logic [11:0] instr,      // Instruction word
    output var  op_e         op          // Selected operation
);
    // ------------------------------------------------------------------------
    // Opcode match
    // ------------------------------------------------------------------------
    // Pure combinational decode; tristate_load_op accepts only the port direction selector
    always_comb begin
        op = OP_NONE;
        if (instr[`OPC7_HI:`OPC7_LO] == `SWAP_OPC) begin
            op = OP_SWAP;
        end else if (instr[`TRISTATE_LOAD_OP_OPC_HI:`TRISTATE_LOAD_OP_OPC_LO] == `TRISTATE_LOAD_OP_OPC &&
                     instr[`TRISTATE_LOAD_OP_SEL_HI:`TRISTATE_LOAD_OP_SEL_LO] == `TRISTATE_LOAD_OP_GP_SEL) begin
            op = OP_TRISTATE_LOAD_OP;
        end else if (instr[`XOR_OPC_HI:`XOR_OPC_LO] == `XOR_OPC) begin
            op = OP_XOR;
        end
    end
endmodule // exec_decode
`default_nettype wire

/* File: src/nibble_swap_tristate_load_op_xor_exec.sv */
// Execute stage for nibble swap, tristate load and xor literal operations
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
`include "exec_map.svh"
module nibble_swap_tristate_load_op_xor_exec
    import exec_pkg::*;
(
    input  wire logic        ref_clk,    // Core clock
    input  wire logic        arst_n,     // Asynchronous reset, active low
    input  wire logic        cycle_en,   // One-cycle instruction cycle enable
    input  wire logic        instr_vld,  // Instruction word is valid this cycle
    input  wire logic [11:0] instr,      // Instruction word from decode
    input  wire logic [7:0]  file_rdata, // Contents of the addressed file register
    input  wire logic        zero_in,    // Zero flag as held by the status register
    output logic      [4:0]  file_raddr, // File register read address
    output file_wr_s         file_wr,    // File register write request
    output logic      [7:0]  acc_q,      // Working accumulator
    output logic      [7:0]  port_dir_q, // Port direction register
    output logic             zero_q,     // Zero flag
    output logic             zero_we     // Zero flag written this cycle
);
    // ------------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------------
    op_e        op;                      // Decoded operation
    logic       fire;                    // Instruction executes this cycle
    logic [7:0] swapped;                 // Nibble-exchanged file value
    logic [7:0] xor_res;                 // Accumulator xor literal
    logic       dest_file;               // Destination bit of the swap

    exec_decode u_dec (
        .instr (instr),
        .op    (op)
    );

    // Read address is combinational so the file value arrives in the same cycle
    // A word only counts when the instruction-cycle enable and valid meet
    assign fire       = cycle_en && instr_vld;
    assign file_raddr = instr[`FADDR_HI:`FADDR_LO];
    assign dest_file  = instr[`DEST_BIT];
    assign swapped    = {file_rdata[`NIB_LO_HI:`NIB_LO_LO],
                         file_rdata[`NIB_HI_HI:`NIB_HI_LO]};
    assign xor_res    = acc_q ^ instr[`LIT_HI:`LIT_LO];

    // ------------------------------------------------------------------------
    // Accumulator
    // ------------------------------------------------------------------------
    // Updated at the enable edge so the next instruction sees the result
    // Tristate load reads the old value, so back-to-back words stay consistent
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            acc_q <= `ACC_RST;
        end else if (fire) begin
            if (op == OP_SWAP && !dest_file) begin
                acc_q <= swapped;
            end else if (op == OP_XOR) begin
                acc_q <= xor_res;
            end
        end
    end

    // ------------------------------------------------------------------------
    // File register write-back
    // ------------------------------------------------------------------------
    // Registered request; register file commits it one clock later
    // Address and data lanes follow every word; only the enable marks a write
    // Trade-off: fewer enables on the lanes at the cost of some toggling
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            file_wr <= '0;
        end else begin
            file_wr.en   <= fire && op == OP_SWAP && dest_file;
            file_wr.addr <= instr[`FADDR_HI:`FADDR_LO];
            file_wr.data <= swapped;
        end
    end

    // ------------------------------------------------------------------------
    // Port direction register
    // ------------------------------------------------------------------------
    // Reset to all inputs, the safe state for pins
    // Only the selector six word reaches this register; others are ignored
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            port_dir_q <= `DIR_RST;
        end else if (fire && op == OP_TRISTATE_LOAD_OP) begin
            port_dir_q <= acc_q;
        end
    end

    // ------------------------------------------------------------------------
    // Zero flag
    // ------------------------------------------------------------------------
    // Only xor touches the flag; others keep the status register value
    // Limitation: the status owner must commit the flag only on zero_we,
    // since zero_q merely mirrors the incoming flag on other cycles
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            zero_q  <= 1'b0;
            zero_we <= 1'b0;
        end else begin
            zero_we <= fire && op == OP_XOR;
            if (fire && op == OP_XOR) begin
                zero_q <= (xor_res == `ZERO_BYTE);
            end else begin
                zero_q <= zero_in;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_swap_to_acc: assert property (@(posedge ref_clk) disable iff (!arst_n)
        fire && op == OP_SWAP && !dest_file |=> acc_q == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
        else $error("swap to accumulator wrong");
    a_swap_to_file: assert property (@(posedge ref_clk) disable iff (!arst_n)
        fire && op == OP_SWAP && dest_file |=> file_wr.en && file_wr.data == {$past(file_rdata[3:0]),
        $past(file_rdata[7:4])} && $stable(acc_q))
        else $error("swap to file wrong");
    a_tristate_load_op_sel_only: assert property (@(posedge ref_clk) disable iff (!arst_n)
        fire && instr[11:3] == 9'h000 && instr[2:0] != 3'h6 |=> $stable(port_dir_q))
        else $error("tristate_load_op accepted bad selector");
    a_tristate_load_op_load: assert property (@(posedge ref_clk) disable iff (!arst_n)
        fire && op == OP_TRISTATE_LOAD_OP |=> port_dir_q == $past(acc_q) && !zero_we && $stable(acc_q))
        else $error("tristate_load_op load wrong");
    a_xor_result: assert property (@(posedge ref_clk) disable iff (!arst_n)
        fire && op == OP_XOR |=> acc_q == ($past(acc_q) ^ $past(instr[7:0])))
        else $error("xor result wrong");
    a_xor_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
        fire && op == OP_XOR |=> zero_we && zero_q == (acc_q == 8'h00))
        else $error("zero flag wrong");
    a_swap_no_flag: assert property (@(posedge ref_clk) disable iff (!arst_n)
        fire && op == OP_SWAP |=> !zero_we)
        else $error("swap touched flag");
    a_idle_hold: assert property (@(posedge ref_clk) disable iff (!arst_n)
        !fire |=> $stable(acc_q) && $stable(port_dir_q) && !file_wr.en && !zero_we)
        else $error("state moved without instruction");

    // ------------------------------------------------------------------------
    // Further checks on side effects
    // ------------------------------------------------------------------------

    // Swap to file must target the register that was read
    // A wrong address would corrupt an unrelated file register
    a_swap_file_addr: assert property (@(posedge ref_clk) disable iff (!arst_n)
        fire && op == OP_SWAP && dest_file |=> file_wr.addr == $past(instr[`FADDR_HI:`FADDR_LO]))
        else $error("swap write address wrong");

    // Swap to accumulator must not also write the file
    // Double writes would hide a destination decode fault
    a_swap_acc_nowr: assert property (@(posedge ref_clk) disable iff (!arst_n)
        fire && op == OP_SWAP && !dest_file |=> !file_wr.en)
        else $error("swap to accumulator wrote file");

    // Swap never moves the port direction register
    // Pins must not change direction as a side effect
    a_swap_keep_dir: assert property (@(posedge ref_clk) disable iff (!arst_n)
        fire && op == OP_SWAP |=> $stable(port_dir_q))
        else $error("swap moved port direction");

    // Decoder flags tristate load only for selector six
    // Checked on the decode itself, not only on its effect
    a_tristate_load_op_decode: assert property (@(posedge ref_clk) disable iff (!arst_n)
        op == OP_TRISTATE_LOAD_OP |-> instr[`TRISTATE_LOAD_OP_SEL_HI:`TRISTATE_LOAD_OP_SEL_LO] == `TRISTATE_LOAD_OP_GP_SEL)
        else $error("tristate_load_op decoded for bad selector");

    // Tristate load writes no file register
    // The accumulator copy goes to the direction register only
    a_tristate_load_op_no_wr: assert property (@(posedge ref_clk) disable iff (!arst_n)
        fire && op == OP_TRISTATE_LOAD_OP |=> !file_wr.en)
        else $error("tristate_load_op wrote file");

    // Tristate load passes the status zero flag through unchanged
    // The flag must read as it did before the word
    a_tristate_load_op_zero_pass: assert property (@(posedge ref_clk) disable iff (!arst_n)
        fire && op == OP_TRISTATE_LOAD_OP |=> zero_q == $past(zero_in))
        else $error("tristate_load_op changed zero flag");

    // Decoder flags xor only for the all-ones top nibble
    // Guards against a literal being taken from another opcode
    a_xor_decode: assert property (@(posedge ref_clk) disable iff (!arst_n)
        op == OP_XOR |-> instr[`XOR_OPC_HI:`XOR_OPC_LO] == `XOR_OPC)
        else $error("xor decoded for bad opcode");

    // Xor result goes to the accumulator only
    // No file write and no direction change may follow it
    a_xor_no_wr: assert property (@(posedge ref_clk) disable iff (!arst_n)
        fire && op == OP_XOR |=> !file_wr.en && $stable(port_dir_q))
        else $error("xor wrote outside accumulator");

    // Swap passes the status zero flag through unchanged
    // Flag owner sees no write pulse and the old value
    a_swap_zero_pass: assert property (@(posedge ref_clk) disable iff (!arst_n)
        fire && op == OP_SWAP |=> zero_q == $past(zero_in))
        else $error("swap changed zero flag");

    // A zero write pulse only ever follows an executed xor
    // Stray pulses would clobber the status register
    a_zero_we_src: assert property (@(posedge ref_clk) disable iff (!arst_n)
        zero_we |-> $past(fire) && $past(op) == OP_XOR)
        else $error("zero write without xor");

    // A file write only ever follows an executed swap to file
    // Results land in the cycle straight after the word
    a_file_we_src: assert property (@(posedge ref_clk) disable iff (!arst_n)
        file_wr.en |-> $past(fire) && $past(op) == OP_SWAP && $past(dest_file))
        else $error("file write without swap");

    // Unknown words executed leave every result untouched
    // Other opcodes belong to logic outside this block
    a_none_no_effect: assert property (@(posedge ref_clk) disable iff (!arst_n)
        fire && op == OP_NONE |=> $stable(acc_q) && $stable(port_dir_q) && !file_wr.en && !zero_we)
        else $error("unknown word changed state");
endmodule // nibble_swap_tristate_load_op_xor_exec
`default_nettype wire

/* File: testbench/nibble_swap_tristate_load_op_xor_exec_bench.sv */
// Self-checking bench for the nibble swap, tristate load and xor literal execute block
`timescale 1ns/1ps
`default_nettype none
module nibble_swap_tristate_load_op_xor_exec_bench
    import exec_pkg::*;
;
    // ------------------------------------------------------------------------
    // Stimulus, outputs and the bench's own model
    // ------------------------------------------------------------------------
    logic        ref_clk    = 1'b0;    // Core clock, 8 ns period
    logic        arst_n     = 1'b0;    // Reset held from time zero
    logic        cycle_en   = 1'b0;    // Instruction cycle enable
    logic        instr_vld  = 1'b0;    // Instruction valid
    logic [11:0] instr      = 12'h000; // Instruction word
    logic [7:0]  file_rdata = 8'h00;   // Addressed file register contents
    logic        zero_in    = 1'b0;    // Zero flag from status register
    logic [4:0]  file_raddr;           // Read address seen
    file_wr_s    file_wr;              // Write request seen
    logic [7:0]  acc_q;                // Accumulator seen
    logic [7:0]  port_dir_q;           // Port direction seen
    logic        zero_q;               // Zero flag seen
    logic        zero_we;              // Zero write pulse seen
    logic [7:0]  exp_acc = 8'h00;      // Expected accumulator
    logic [7:0]  exp_dir = 8'hFF;      // Expected port direction, all inputs at reset
    logic [13:0] exp_wr  = 14'h0000;   // Expected write request
    logic        exp_zwe = 1'b0;       // Expected zero write pulse
    logic        exp_z   = 1'b0;       // Expected zero flag after xor
    int          failures  = 0;        // Mismatch count
    int          tests_run = 0;        // Comparison count

    nibble_swap_tristate_load_op_xor_exec dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .cycle_en(cycle_en), .instr_vld(instr_vld),
        .instr(instr), .file_rdata(file_rdata), .zero_in(zero_in), .file_raddr(file_raddr),
        .file_wr(file_wr), .acc_q(acc_q), .port_dir_q(port_dir_q), .zero_q(zero_q),
        .zero_we(zero_we)
    );

    // Free-running clock
    always #4 ref_clk = ~ref_clk;

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    // Single comparison point so every check is counted
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Expected nibble exchange
    function automatic logic [7:0] swap_nib(input logic [7:0] v);
        return {v[3:0], v[7:4]};
    endfunction

    // Drive one word; check the previous word's results one edge later, so words run back to back
    task automatic step(input logic [11:0] iw, input logic go, input logic [7:0] rd);
        logic zin;                     // Status zero flag offered this word
        zin = 1'($urandom_range(0, 1));
        @(posedge ref_clk);
        instr      <= iw;
        {cycle_en, instr_vld} <= go ? 2'b11 : 2'($urandom_range(0, 2)); // Never both high unless taken
        file_rdata <= rd;
        zero_in    <= zin;
        @(negedge ref_clk);
        chk(acc_q, exp_acc);
        chk(port_dir_q, exp_dir);
        chk(file_wr, exp_wr);
        chk(zero_we, exp_zwe);
        chk(zero_q, exp_z);
        chk(file_raddr, iw[4:0]);
        // Address and data lanes follow every word; only the enable marks a real write
        exp_wr  = {1'b0, iw[4:0], swap_nib(rd)};
        exp_zwe = 1'b0;
        exp_z   = zin;
        if (go) begin
            if (iw[11:6] == 6'h0E) begin
                if (iw[5]) exp_wr[13] = 1'b1;
                else exp_acc = swap_nib(rd);
            end else if (iw == 12'h006) begin
                exp_dir = exp_acc;
            end else if (iw[11:8] == 4'hF) begin
                exp_acc = exp_acc ^ iw[7:0];
                exp_zwe = 1'b1;
                exp_z   = (exp_acc == 8'h00);
            end
        end
    endtask

    // Verdict and end of run
    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial begin
        void'($urandom(12668));
        repeat (8) @(posedge ref_clk);
        arst_n <= 1'b1;
        // Hand-picked words: xor chain, swap both ways, tristate_load_op, xor to zero
        step(12'hFB5, 1'b1, 8'h00);
        step(12'hFAF, 1'b1, 8'h00);
        step(12'h3A5, 1'b1, 8'hA5);
        step(12'h385, 1'b1, 8'hA5);
        step(12'h006, 1'b1, 8'h00);
        step(12'hF5A, 1'b1, 8'h00);
        $display("Test corner words done");
        // Every tristate selector; only six may load the direction register
        for (int s = 0; s < 8; s++) begin
            step({4'hF, 8'($urandom)}, 1'b1, 8'h00);
            step({9'h000, 3'(s)}, 1'b1, 8'h00);
        end
        $display("Test tristate selectors done");
        // Random mix of all three operations, other opcodes and idle cycles
        for (int i = 0; i < 300; i++) begin
            case ($urandom_range(0, 3))
                0: step({6'h0E, 6'($urandom)}, ($urandom_range(0, 3) != 0), 8'($urandom));
                1: step({9'h000, 3'($urandom)}, ($urandom_range(0, 3) != 0), 8'($urandom));
                2: step({4'hF, 8'($urandom)}, ($urandom_range(0, 3) != 0), 8'($urandom));
                default: step(12'($urandom), ($urandom_range(0, 3) != 0), 8'($urandom));
            endcase
        end
        step(12'h000, 1'b0, 8'h00);
        $display("Test random mix done");
        final_report();
    end

    // Watchdog, far beyond the few thousand nanoseconds the tests need
    initial begin
        #50000;
        failures++;
        final_report();
    end
endmodule // nibble_swap_tristate_load_op_xor_exec_bench
`default_nettype wire
